// ### sid_status_indicator_driver.sv
// Front panel lamp driver with blink time bases, registers and interrupt
// Summary of operation
// - Health lamp steady lit when supply present and lit-type fault flagged.
// - Health lamp dark with no supply or a dark-type fault.
// - Health lamp blinks one second on, one second off in normal operation.
// - Health lamp blinks 0.125 s on/off while loading or not started.
// - Alarm lamp steady lit for an alarm needing module replacement.
// - Alarm lamp blinks one second on/off for an alarm from related parts.
// - Alarm lamp dark while no alarm is active.
// - Activity lamp lit when running with transmit on, or loading idle.
// - Activity lamp blinks one second on/off when running with transmit off.
// - Reflected-power lamp follows the standing-wave alarm, lit or dark.
// - Two link lamps, identical logic each, steady green when link healthy.
// - Link lamp steady red when its optics cannot send or receive.
// - Link lamp blinks red one second on/off on lost lock.
// - Link lamp dark when its optics are absent or unpowered.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module sid_status_indicator_driver
    import sid_pkg::*;
#(
    parameter int SLOW_CYC = sid_pkg::SLOW_HALF_CYC,
    parameter int FAST_CYC = sid_pkg::FAST_HALF_CYC,
    parameter int NUM_LINKS = 2
) (
    input logic sys_clk,
    input logic rst,
    input sid_pkg::sid_unit_t unitSt,
    input sid_pkg::sid_alarm_t alarmSt,
    input sid_pkg::sid_link_t [NUM_LINKS-1:0] linkSt,
    input logic [sid_pkg::ADDR_W-1:0] addr,
    input logic [sid_pkg::DATA_W-1:0] wrData,
    input logic wrStb,
    input logic rdStb,
    output logic [sid_pkg::DATA_W-1:0] rdData,
    output logic irq,
    output logic healthLamp,
    output logic alarmLamp,
    output logic activityLamp,
    output logic swrLamp,
    output logic [NUM_LINKS-1:0] linkLampGreen,
    output logic [NUM_LINKS-1:0] linkLampRed
);
    import sid_pkg::*;

    localparam int CNT_W = $clog2((SLOW_CYC > FAST_CYC) ? SLOW_CYC : FAST_CYC);
    localparam int EV_N = EV_LINK0 + NUM_LINKS;
    localparam int LAMP_N = LMP_LINK0 + NUM_LINKS;

    function automatic logic cntLast(input logic [CNT_W-1:0] cnt, input int lim);
        cntLast = (cnt == CNT_W'(lim - 1));
    endfunction

    function automatic logic lampDrive(input sid_mode_t m, input logic slow,
                                       input logic fast);
        unique case (m)
            MODE_OFF: lampDrive = 1'b0;
            MODE_ON: lampDrive = 1'b1;
            MODE_SLOW: lampDrive = slow;
            MODE_FAST: lampDrive = fast;
        endcase
    endfunction

    logic [CNT_W-1:0] slowCnt_r;
    logic [CNT_W-1:0] fastCnt_r;
    logic slowPhase_r;
    logic fastPhase_r;
    logic ctrlEn_r;
    logic [EV_N-1:0] irqStat_r;
    logic [EV_N-1:0] irqMask_r;
    logic [EV_N-1:0] evPrev_r;
    logic [EV_N-1:0] evLevel;
    logic [EV_N-1:0] evSet;
    logic [EV_N-1:0] evClr;
    logic [DATA_W-1:0] modeWord_r;
    logic [DATA_W-1:0] modeWord_nxt;
    logic [DATA_W-1:0] rdMux;
    sid_mode_t lampMode [LAMP_N];
    logic [NUM_LINKS-1:0] linkRedSel;
    logic normalRun;

    ////////////////////////////////////////////////////////////////////////////
    // Time bases; slow is an exact multiple of fast so both wrap together
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            slowCnt_r <= '0;
            slowPhase_r <= 1'b1;
        end else if (cntLast(slowCnt_r, SLOW_CYC)) begin
            slowCnt_r <= '0;
            slowPhase_r <= ~slowPhase_r;
        end else begin
            slowCnt_r <= slowCnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fastCnt_r <= '0;
            fastPhase_r <= 1'b1;
        end else if (cntLast(fastCnt_r, FAST_CYC)) begin
            fastCnt_r <= '0;
            fastPhase_r <= ~fastPhase_r;
        end else begin
            fastCnt_r <= fastCnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lamp mode selection, highest priority first
    assign normalRun = unitSt.powerOk && !unitSt.faultDark && !unitSt.faultLit &&
                       !unitSt.swLoading && !unitSt.notStarted;

    always_comb begin
        if (!unitSt.powerOk || unitSt.faultDark) begin
            lampMode[LMP_HEALTH] = MODE_OFF;
        end else if (unitSt.faultLit) begin
            lampMode[LMP_HEALTH] = MODE_ON;
        end else if (unitSt.swLoading || unitSt.notStarted) begin
            lampMode[LMP_HEALTH] = MODE_FAST;
        end else begin
            lampMode[LMP_HEALTH] = MODE_SLOW;
        end
        if (alarmSt.alarmReplace) begin
            lampMode[LMP_ALARM] = MODE_ON;
        end else if (alarmSt.alarmRelated) begin
            lampMode[LMP_ALARM] = MODE_SLOW;
        end else begin
            lampMode[LMP_ALARM] = MODE_OFF;
        end
        if (!unitSt.powerOk) begin
            lampMode[LMP_ACT] = MODE_OFF;
        end else if (unitSt.swLoading && !unitSt.radioRunning) begin
            lampMode[LMP_ACT] = MODE_ON;
        end else if (normalRun && unitSt.txEnabled) begin
            lampMode[LMP_ACT] = MODE_ON;
        end else if (normalRun) begin
            lampMode[LMP_ACT] = MODE_SLOW;
        end else begin
            lampMode[LMP_ACT] = MODE_OFF;
        end
        lampMode[LMP_SWR] = alarmSt.swrAlarm ? MODE_ON : MODE_OFF;
        for (int i = 0; i < NUM_LINKS; i++) begin
            linkRedSel[i] = 1'b1;
            if (!linkSt[i].present || !linkSt[i].powered) begin
                lampMode[LMP_LINK0+i] = MODE_OFF;
            end else if (linkSt[i].txRxFail) begin
                lampMode[LMP_LINK0+i] = MODE_ON;
            end else if (linkSt[i].lockLost) begin
                lampMode[LMP_LINK0+i] = MODE_SLOW;
            end else if (linkSt[i].linkUp) begin
                lampMode[LMP_LINK0+i] = MODE_ON;
                linkRedSel[i] = 1'b0;
            end else begin
                lampMode[LMP_LINK0+i] = MODE_OFF;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lamp outputs; disabling lamps blanks all of them without touching modes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            healthLamp <= 1'b0;
            alarmLamp <= 1'b0;
            activityLamp <= 1'b0;
            swrLamp <= 1'b0;
        end else begin
            healthLamp <= ctrlEn_r && lampDrive(lampMode[LMP_HEALTH], slowPhase_r,
                                                fastPhase_r);
            alarmLamp <= ctrlEn_r && lampDrive(lampMode[LMP_ALARM], slowPhase_r,
                                               fastPhase_r);
            activityLamp <= ctrlEn_r && lampDrive(lampMode[LMP_ACT], slowPhase_r,
                                                  fastPhase_r);
            swrLamp <= ctrlEn_r && lampDrive(lampMode[LMP_SWR], slowPhase_r,
                                             fastPhase_r);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            linkLampGreen <= '0;
            linkLampRed <= '0;
        end else begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                linkLampGreen[i] <= ctrlEn_r && !linkRedSel[i] &&
                    lampDrive(lampMode[LMP_LINK0+i], slowPhase_r, fastPhase_r);
                linkLampRed[i] <= ctrlEn_r && linkRedSel[i] &&
                    lampDrive(lampMode[LMP_LINK0+i], slowPhase_r, fastPhase_r);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode readback word
    always_comb begin
        modeWord_nxt = '0;
        for (int i = 0; i < LAMP_N; i++) begin
            modeWord_nxt[i*MODE_FLD_W +: MODE_FLD_W] = lampMode[i];
        end
        for (int i = 0; i < NUM_LINKS; i++) begin
            modeWord_nxt[LINK_RED_POS+i] = linkRedSel[i] &&
                                           (lampMode[LMP_LINK0+i] != MODE_OFF);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            modeWord_r <= '0;
        end else begin
            modeWord_r <= modeWord_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events: rising edge of each alarm or link fault
    always_comb begin
        evLevel = '0;
        evLevel[EV_ALM_REPLACE] = alarmSt.alarmReplace;
        evLevel[EV_ALM_RELATED] = alarmSt.alarmRelated;
        evLevel[EV_SWR] = alarmSt.swrAlarm;
        for (int i = 0; i < NUM_LINKS; i++) begin
            evLevel[EV_LINK0+i] = modeWord_nxt[LINK_RED_POS+i];
        end
    end

    assign evSet = evLevel & ~evPrev_r;
    assign evClr = (wrStb && addr == REG_IRQ_STAT) ? wrData[EV_N-1:0] : '0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            evPrev_r <= '0;
        end else begin
            evPrev_r <= evLevel;
        end
    end

    // A set in the clearing cycle survives
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqStat_r <= '0;
        end else begin
            irqStat_r <= (irqStat_r & ~evClr) | evSet;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_r & irqMask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrlEn_r <= CTRL_EN_RESET;
            irqMask_r <= '0;
        end else if (wrStb) begin
            if (addr == REG_CTRL) begin
                ctrlEn_r <= wrData[CTRL_EN_BIT];
            end
            if (addr == REG_IRQ_MASK) begin
                irqMask_r <= wrData[EV_N-1:0];
            end
        end
    end

    always_comb begin
        rdMux = '0;
        case (addr)
            REG_CTRL: rdMux[CTRL_EN_BIT] = ctrlEn_r;
            REG_MODE: rdMux = modeWord_r;
            REG_IRQ_STAT: rdMux[EV_N-1:0] = irqStat_r;
            REG_IRQ_MASK: rdMux[EV_N-1:0] = irqMask_r;
            default: rdMux = '0;
        endcase
    end

    // Data shows only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdData <= '0;
        end else begin
            rdData <= rdStb ? rdMux : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence faultClear;
        wrStb && addr == REG_IRQ_STAT && wrData[EV_SWR] && !evSet[EV_SWR];
    endsequence

    chk_health_lit: assert property (
        (unitSt.powerOk && unitSt.faultLit && !unitSt.faultDark && ctrlEn_r)
        |=> healthLamp) else $error("health lamp not lit on fault");
    chk_health_dark: assert property (
        (!unitSt.powerOk || unitSt.faultDark) |=> !healthLamp)
        else $error("health lamp lit without supply");
    chk_health_slow: assert property (
        (normalRun && ctrlEn_r) |=> healthLamp == $past(slowPhase_r))
        else $error("health lamp not on slow base");
    chk_health_fast: assert property (
        (unitSt.powerOk && !unitSt.faultLit && !unitSt.faultDark && ctrlEn_r &&
         (unitSt.swLoading || unitSt.notStarted)) |=> healthLamp == $past(fastPhase_r))
        else $error("health lamp not on fast base");
    chk_alarm_steady: assert property (
        (alarmSt.alarmReplace && ctrlEn_r) |=> alarmLamp)
        else $error("alarm lamp not steady");
    chk_alarm_blink: assert property (
        (!alarmSt.alarmReplace && alarmSt.alarmRelated && ctrlEn_r)
        |=> alarmLamp == $past(slowPhase_r)) else $error("alarm lamp not blinking");
    chk_alarm_dark: assert property (
        (!alarmSt.alarmReplace && !alarmSt.alarmRelated) |=> !alarmLamp)
        else $error("alarm lamp lit with no alarm");
    chk_act_steady: assert property (
        (normalRun && unitSt.txEnabled && ctrlEn_r) |=> activityLamp)
        else $error("activity lamp not steady");
    chk_act_blink: assert property (
        (normalRun && !unitSt.txEnabled && ctrlEn_r)
        |=> activityLamp == $past(slowPhase_r)) else $error("activity lamp not blinking");
    chk_swr_follow: assert property (
        ctrlEn_r |=> swrLamp == $past(alarmSt.swrAlarm))
        else $error("reflected-power lamp wrong");
    chk_phase_hold: assert property (
        !cntLast(slowCnt_r, SLOW_CYC) |=> $stable(slowPhase_r))
        else $error("slow base toggled early");
    chk_phase_align: assert property (
        $changed(slowPhase_r) |-> $changed(fastPhase_r))
        else $error("time bases out of phase");
    chk_irq_level: assert property (
        (|(irqStat_r & irqMask_r)) |=> irq) else $error("interrupt not raised");
    chk_stat_clear: assert property (
        faultClear |=> !irqStat_r[EV_SWR]) else $error("status bit not cleared");
    chk_read_idle: assert property (
        !rdStb |=> rdData == '0) else $error("read data outside slot");

    for (genvar g = 0; g < NUM_LINKS; g++) begin : gLinkChk
        chk_link_green: assert property (
            (linkSt[g].present && linkSt[g].powered && !linkSt[g].txRxFail &&
             !linkSt[g].lockLost && linkSt[g].linkUp && ctrlEn_r)
            |=> linkLampGreen[g] && !linkLampRed[g]) else $error("link not green");
        chk_link_red: assert property (
            (linkSt[g].present && linkSt[g].powered && linkSt[g].txRxFail && ctrlEn_r)
            |=> linkLampRed[g] && !linkLampGreen[g]) else $error("link not red");
        chk_link_lock: assert property (
            (linkSt[g].present && linkSt[g].powered && !linkSt[g].txRxFail &&
             linkSt[g].lockLost && ctrlEn_r)
            |=> linkLampRed[g] == $past(slowPhase_r) && !linkLampGreen[g])
            else $error("link not blinking red");
        chk_link_dark: assert property (
            (!linkSt[g].present || !linkSt[g].powered)
            |=> !linkLampRed[g] && !linkLampGreen[g]) else $error("link lamp lit");
    end

endmodule

// ### sid_pkg.sv
// Constants, register map and carrier types for the status indicator driver
package sid_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_KHZ = 250000;
    localparam int SLOW_HALF_MS = 1000;
    localparam int FAST_HALF_MS = 125;
    localparam int SLOW_HALF_CYC = SLOW_HALF_MS * CLK_KHZ;
    localparam int FAST_HALF_CYC = FAST_HALF_MS * CLK_KHZ;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MODE = 4'h4;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h8;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hc;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'h1;
    localparam int MODE_FLD_W = 2;
    localparam int LINK_RED_POS = 12;
    localparam int EV_ALM_REPLACE = 0;
    localparam int EV_ALM_RELATED = 1;
    localparam int EV_SWR = 2;
    localparam int EV_LINK0 = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Lamp slots in the mode word
    localparam int LMP_HEALTH = 0;
    localparam int LMP_ALARM = 1;
    localparam int LMP_ACT = 2;
    localparam int LMP_SWR = 3;
    localparam int LMP_LINK0 = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_ON = 2'h1,
        MODE_SLOW = 2'h3,
        MODE_FAST = 2'h2
    } sid_mode_t;

    typedef struct packed {
        logic powerOk;
        logic faultLit;
        logic faultDark;
        logic swLoading;
        logic notStarted;
        logic radioRunning;
        logic txEnabled;
    } sid_unit_t;

    typedef struct packed {
        logic alarmReplace;
        logic alarmRelated;
        logic swrAlarm;
    } sid_alarm_t;

    typedef struct packed {
        logic present;
        logic powered;
        logic linkUp;
        logic txRxFail;
        logic lockLost;
    } sid_link_t;

endpackage

// ### sid_lamp_panel.sv
// Panel observer model: toggle counts and finished run lengths per lamp
`timescale 1ns/1ps
module sid_lamp_panel (
    input logic sys_clk,
    input logic rst,
    input logic [7:0] lamps,
    output logic [7:0][15:0] toggles,
    output logic [7:0][15:0] lastOn,
    output logic [7:0][15:0] lastOff
);
    logic [7:0] lampPrev_r;
    logic [7:0][15:0] runLen_r;

    ////////////////////////////////////////////////////////////////////////////
    // An eye only judges whole runs, so a run is logged once it ends
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lampPrev_r <= 8'h00;
            runLen_r <= '0;
            toggles <= '0;
            lastOn <= '0;
            lastOff <= '0;
        end else begin
            lampPrev_r <= lamps;
            for (int i = 0; i < 8; i++) begin
                if (lamps[i] === lampPrev_r[i]) begin
                    runLen_r[i] <= runLen_r[i] + 16'h0001;
                end else begin
                    toggles[i] <= toggles[i] + 16'h0001;
                    runLen_r[i] <= 16'h0001;
                    if (lampPrev_r[i]) begin
                        lastOn[i] <= runLen_r[i];
                    end else begin
                        lastOff[i] <= runLen_r[i];
                    end
                end
            end
        end
    end
endmodule

// ### sid_status_indicator_driver_tb.sv
// Self-checking testbench for the status indicator driver
`timescale 1ns/1ps
module sid_status_indicator_driver_tb;
    import sid_pkg::*;
    // Short blink counts keep the run small; slow is a multiple of fast
    localparam int SLOW = 64;
    localparam int FAST = 8;
    localparam int WIN = 4 * SLOW;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    sid_unit_t unitSt = '0;
    sid_alarm_t alarmSt = '0;
    sid_link_t [1:0] linkSt = '0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wrData = '0;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    logic [DATA_W-1:0] rdData;
    logic irq, healthLamp, alarmLamp, activityLamp, swrLamp;
    logic [1:0] linkLampGreen, linkLampRed;
    logic [7:0] lampVec;
    logic [7:0][15:0] toggles, lastOn, lastOff, togSnap;
    logic [31:0] rd;
    int n_mismatch = 0;
    int checks = 0;

    always #2 sys_clk = ~sys_clk;
    assign lampVec = {linkLampGreen[1], linkLampRed[1], linkLampGreen[0], linkLampRed[0],
        swrLamp, activityLamp, alarmLamp, healthLamp};

    sid_status_indicator_driver #(.SLOW_CYC(SLOW), .FAST_CYC(FAST), .NUM_LINKS(2))
        i_sid_status_indicator_driver (.sys_clk(sys_clk), .rst(rst), .unitSt(unitSt),
        .alarmSt(alarmSt), .linkSt(linkSt), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .irq(irq), .healthLamp(healthLamp),
        .alarmLamp(alarmLamp), .activityLamp(activityLamp), .swrLamp(swrLamp),
        .linkLampGreen(linkLampGreen), .linkLampRed(linkLampRed));

    sid_lamp_panel i_sid_lamp_panel (.sys_clk(sys_clk), .rst(rst), .lamps(lampVec),
        .toggles(toggles), .lastOn(lastOn), .lastOff(lastOff));

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge sys_clk);
        wrStb <= 1'b0;
    endtask

    task automatic rdReg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge sys_clk);
        rdStb <= 1'b0;
        #1;
        d = rdData;
    endtask

    // Drives all status levels, lets them settle, then watches a full window
    task automatic apply(input logic [6:0] u, input logic [2:0] a, input logic [4:0] l0,
        input logic [4:0] l1);
        @(posedge sys_clk);
        unitSt <= sid_unit_t'(u);
        alarmSt <= sid_alarm_t'(a);
        linkSt <= {sid_link_t'(l1), sid_link_t'(l0)};
        repeat (4) @(posedge sys_clk);
        #1;
        togSnap = toggles;
        repeat (WIN) @(posedge sys_clk);
        #1;
    endtask

    task automatic steady(input int idx, input logic v);
        check({31'h0, lampVec[idx]}, {31'h0, v});
        check({16'h0, toggles[idx] - togSnap[idx]}, 32'h0);
    endtask

    task automatic blink(input int idx, input logic [15:0] half);
        check({16'h0, lastOn[idx]}, {16'h0, half});
        check({16'h0, lastOff[idx]}, {16'h0, half});
        check({31'h0, (toggles[idx] - togSnap[idx]) >= 16'h0003}, 32'h1);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the expected five thousand cycles
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_mismatch++;
        $display("FAIL at %0t: run did not finish", $time);
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rdReg(REG_CTRL, rd);
        check(rd, 32'h0000_0001);
        rdReg(REG_MODE, rd);
        check(rd, 32'h0000_0000);
        rdReg(REG_IRQ_MASK, rd);
        check(rd, 32'h0000_0000);
        rdReg(4'h2, rd);
        check(rd, 32'h0000_0000);
        check({24'h0, lampVec}, 32'h0000_0000);
        $display("test reset_state finished");
        // Interrupt: raise, mask, clear
        wrReg(REG_IRQ_MASK, 32'h0000_0001);
        apply(7'h00, 3'h4, 5'h00, 5'h00);
        rdReg(REG_IRQ_STAT, rd);
        check(rd, 32'h0000_0001);
        check({31'h0, irq}, 32'h1);
        apply(7'h00, 3'h5, 5'h1e, 5'h00);
        wrReg(REG_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        #1;
        check({31'h0, irq}, 32'h0);
        rdReg(REG_IRQ_STAT, rd);
        check(rd, 32'h0000_000c);
        wrReg(REG_IRQ_STAT, 32'h0000_001f);
        wrReg(REG_IRQ_MASK, 32'h0000_0000);
        rdReg(REG_IRQ_STAT, rd);
        check(rd, 32'h0000_0000);
        $display("test interrupt finished");
        // Health and activity lamps
        apply(7'h60, 3'h0, 5'h00, 5'h00);
        steady(0, 1'b1);
        apply(7'h70, 3'h0, 5'h00, 5'h00);
        steady(0, 1'b0);
        apply(7'h03, 3'h0, 5'h00, 5'h00);
        steady(0, 1'b0);
        apply(7'h42, 3'h0, 5'h00, 5'h00);
        blink(0, 16'(SLOW));
        blink(2, 16'(SLOW));
        apply(7'h48, 3'h0, 5'h00, 5'h00);
        blink(0, 16'(FAST));
        steady(2, 1'b1);
        apply(7'h44, 3'h0, 5'h00, 5'h00);
        blink(0, 16'(FAST));
        apply(7'h58, 3'h0, 5'h00, 5'h00);
        steady(0, 1'b0);
        $display("test health_activity finished");
        // Alarm and reflected-power lamps
        apply(7'h43, 3'h4, 5'h00, 5'h00);
        steady(1, 1'b1);
        steady(2, 1'b1);
        apply(7'h43, 3'h2, 5'h00, 5'h00);
        blink(1, 16'(SLOW));
        apply(7'h43, 3'h6, 5'h00, 5'h00);
        steady(1, 1'b1);
        apply(7'h43, 3'h1, 5'h00, 5'h00);
        steady(3, 1'b1);
        steady(1, 1'b0);
        apply(7'h43, 3'h0, 5'h00, 5'h00);
        steady(3, 1'b0);
        $display("test alarm_swr finished");
        // Link lamps, each port in a different state
        apply(7'h43, 3'h0, 5'h1c, 5'h1e);
        steady(5, 1'b1);
        steady(4, 1'b0);
        steady(6, 1'b1);
        steady(7, 1'b0);
        apply(7'h43, 3'h0, 5'h19, 5'h0c);
        blink(4, 16'(SLOW));
        steady(5, 1'b0);
        steady(6, 1'b0);
        steady(7, 1'b0);
        apply(7'h43, 3'h0, 5'h14, 5'h19);
        steady(4, 1'b0);
        steady(5, 1'b0);
        blink(6, 16'(SLOW));
        $display("test links finished");
        // Shared slow time base and the mode word
        apply(7'h42, 3'h2, 5'h19, 5'h19);
        rdReg(REG_MODE, rd);
        check(rd, 32'h0000_3f3f);
        for (int n = 0; n < 200; n++) begin
            @(posedge sys_clk);
            #1;
            check({31'h0, (lampVec & 8'h57) == 8'h00 || (lampVec & 8'h57) == 8'h57},
                32'h1);
        end
        wrReg(REG_CTRL, 32'h0000_0000);
        repeat (3) @(posedge sys_clk);
        #1;
        check({24'h0, lampVec}, 32'h0000_0000);
        wrReg(REG_CTRL, 32'h0000_0001);
        $display("test phase_blank finished");
        complete_run();
    end
endmodule
